// ==== pkg/flc_params.svh ====
// Register indices, field positions, reset values and timing for the fuse and lock block
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH

`define FLC_IDX_W           10
`define FLC_IDX_FUSE0       10'h000
`define FLC_IDX_FUSE1       10'h001
`define FLC_IDX_FUSE2       10'h002
`define FLC_IDX_FUSE4       10'h004
`define FLC_IDX_FUSE5       10'h005
`define FLC_IDX_LOCK        10'h007
`define FLC_IDX_CMD         10'h008
`define FLC_IDX_STATUS      10'h009

`define FLC_FUSE_RESET      8'hff
`define FLC_LOCK_RESET      8'hff
`define FLC_LOCK_FIELD_ONES 2'h3

`define FLC_CMD_DEV_RESET   8'h01
`define FLC_CMD_CHIP_ERASE  8'h02

`define FLC_F1_WINDOW_PERIOD_BITS         7:4
`define FLC_F1_PER          3:0
`define FLC_F2_BOOTVEC      6
`define FLC_F2_SLOW_TIMER_OSCILLATOR         5
`define FLC_F2_SLEEP_BROWNOUT_MODE        1:0
`define FLC_F4_RSTDIS       4
`define FLC_F4_STUP         3:2
`define FLC_F4_WATCHDOG_CONFIG_LOCK       1
`define FLC_F4_TESTEN       0
`define FLC_F5_ACTIVE_BROWNOUT_MODE       5:4
`define FLC_F5_EEPROM_PRESERVE       3
`define FLC_F5_BODLVL       2:0
`define FLC_LK_BOOT_WR      6
`define FLC_LK_BOOT_RD      7

`define FLC_ST_BUSY         0
`define FLC_ST_EEPROM_PRESERVE       1
`define FLC_ST_POR          2
`define FLC_ST_EXT          3
`define FLC_ST_SW           4

`define FLC_STUP_SEL_64     2'h0
`define FLC_STUP_SEL_4      2'h1
`define FLC_STUP_SEL_0      2'h3
`define FLC_STUP_CYC_64     7'h40
`define FLC_STUP_CYC_4      7'h04
`define FLC_STUP_CYC_0      7'h00

`define FLC_CLK_PERIOD_NS   40
`define FLC_FUSE_WR_NS      1000
`define FLC_APP_RESET_ADDR  16'h0000

`endif

// ==== pkg/flc_pkg.sv ====
// Types shared by the fuse and lock block
package flc_pkg;

  typedef enum logic [1:0] {
    BOD_RESERVED,
    BOD_SAMPLED,
    BOD_CONTINUOUS,
    BOD_OFF
  } flc_bod_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOAD,
    ST_DELAY,
    ST_RUN
  } flc_rst_state_t;

  typedef struct packed {
    logic [3:0] window_period_bits;
    logic [3:0] timeout_period_bits;
    logic       enable_force;
    logic       config_lock;
  } flc_wdt_cfg_t;

  typedef struct packed {
    flc_bod_mode_t active_brownout_mode;
    flc_bod_mode_t sleep_brownout_mode;
    flc_bod_mode_t effective_mode;
    logic [2:0]    brownout_threshold;
  } flc_bod_cfg_t;

  function automatic flc_bod_mode_t flc_bod_decode(input logic [1:0] code);
    flc_bod_mode_t m;
    m = BOD_RESERVED;
    case (code)
      2'h1:    m = BOD_SAMPLED;
      2'h2:    m = BOD_CONTINUOUS;
      2'h3:    m = BOD_OFF;
      default: m = BOD_RESERVED;
    endcase
    return m;
  endfunction

endpackage

// ==== design/flc_startup_delay.sv ====
// Start-up delay counter timed by low-power oscillator ticks
`timescale 1ns/10ps
`include "flc_params.svh"
module flc_startup_delay
  import flc_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       start,
  input  wire logic [1:0] startup_delay_select,
  input  wire logic       ulp_tick,
  // Result
  output logic            done
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic       active_q;
  logic       active_d;
  logic [6:0] target;

  // Reserved code 10 takes the longest delay so a bad fuse never shortens reset
  always_comb begin
    case (startup_delay_select)
      `FLC_STUP_SEL_4: target = `FLC_STUP_CYC_4;
      `FLC_STUP_SEL_0: target = `FLC_STUP_CYC_0;
      default:         target = `FLC_STUP_CYC_64;
    endcase
  end

  assign done = active_q && (cnt_q == `FLC_STUP_CYC_0);

  always_comb begin
    cnt_d    = cnt_q;
    active_d = active_q;
    if (start) begin
      cnt_d    = target;
      active_d = 1'b1;
    end else if (done) begin
      active_d = 1'b0;
    end else if (active_q && ulp_tick) begin
      cnt_d = cnt_q - 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= `FLC_STUP_CYC_0;
      active_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      active_q <= active_d;
    end
  end

endmodule

// ==== design/flc_top.sv ====
// Fuse bytes, lock bits and the reset-time configuration loader with an APB slave
//
// How it works
// - Each reset copies the user-identifier fuse byte into the test-port identifier.
// - Each reset loads the window-period fuse field into the watchdog window bits.
// - Each reset loads the timeout-period fuse field into the watchdog period bits.
// - Boot-vector fuse zero starts at boot section; one starts at address zero.
// - Slow oscillator pin fuse zero uses separate pins; one shares crystal pins.
// - Sleep brown-out field applies outside idle: 01 sampled, 10 continuous, 11 off.
// - With reset-pin disable programmed, the external reset pin is ignored.
// - Reset-pin, start-up, watchdog-lock and test-port fuses read new only after reset.
// - After reset sources release, hold internal reset 64, 4 or 0 slow ticks.
// - Watchdog-lock zero freezes watchdog setup and forces its enable at reset.
// - Watchdog window enable is never forced; software sets it.
// - Test-port fuse zero enables the test port; one refuses all its access.
// - Active brown-out field applies in active and idle with the same codes.
// - Chip erase clears flash and SRAM; EEPROM too unless preserve fuse is zero.
// - A new EEPROM-preserve value acts once its write timeout ends.
// - A three-bit fuse field picks the brown-out voltage threshold.
// - Boot-section lock writes are taken only when stricter; chip erase unlocks.
// - Boot lock codes: 11 none, 10 no writes, 01 no reads, 00 both.
// - Boot read lock with vectors in application masks interrupts in boot code.
// - Application lock writes are taken only when stricter; chip erase clears.
// - External-program lock field is written only through external programming.
`timescale 1ns/10ps
`include "flc_params.svh"
module flc_top
  import flc_pkg::*;
#(
  parameter int          FUSE_WR_CYCLES  =
    (`FLC_FUSE_WR_NS + `FLC_CLK_PERIOD_NS - 1) / `FLC_CLK_PERIOD_NS,
  parameter logic [15:0] BOOT_START_ADDR = 16'h8000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Marks the current APB transfer as coming from the external programming port
  input  wire logic        prog_access,
  // Pins
  input  wire logic        ext_reset_pin_n,
  input  wire logic        ulp_clk_pin,
  // Processor status
  input  wire logic        exec_in_boot,
  input  wire logic        vectors_in_app,
  input  wire logic        sleeping_deep,
  // Loaded configuration
  output logic             internal_reset_n,
  output logic [15:0]      reset_address,
  output logic [7:0]       test_user_identifier,
  output flc_wdt_cfg_t     wdt_cfg,
  output logic             slow_osc_shared,
  output flc_bod_cfg_t     bod_cfg,
  output logic             test_port_enable,
  // Memory protection
  output logic             boot_write_block,
  output logic             boot_read_block,
  output logic             irq_block,
  // Chip erase strobes
  output logic             erase_flash,
  output logic             erase_sram,
  output logic             erase_eeprom
);

  localparam int CNT_W = $clog2(FUSE_WR_CYCLES + 1);

  // Nonvolatile storage, reset only at power-on
  logic [7:0]     fuse0_q, fuse1_q, fuse2_q, fuse4_q, fuse5_q;
  logic [7:0]     lock_q;
  wire  [7:0]     lock_d;
  logic [7:0]     shadow4_q;
  logic [9:0]     pend_idx_q;
  logic [7:0]     pend_data_q;
  logic [CNT_W-1:0] wr_cnt_q;
  flc_rst_state_t state_q;
  flc_rst_state_t state_d;
  logic [2:0]     cause_q;
  logic [2:0]     cause_d;
  logic           ext_s1_q, ext_s2_q;
  logic           ulp_s1_q, ulp_s2_q, ulp_s3_q;
  logic [31:0]    prdata_q;
  logic           erase_q, erase_ee_q;
  logic           internal_reset_n_q;
  logic [7:0]     tuid_q;
  flc_wdt_cfg_t   wdt_q;
  logic           bootvec_q, slow_timer_oscillator_q;
  logic [1:0]     sleep_brownout_mode_q, active_brownout_mode_q;
  logic [2:0]     bodlvl_q;

  // Address decode
  wire [9:0] reg_idx     = paddr[11:2];
  wire       aligned     = (paddr[1:0] == 2'h0);
  wire       hit_fuse0   = aligned && (reg_idx == `FLC_IDX_FUSE0);
  wire       hit_fuse1   = aligned && (reg_idx == `FLC_IDX_FUSE1);
  wire       hit_fuse2   = aligned && (reg_idx == `FLC_IDX_FUSE2);
  wire       hit_fuse4   = aligned && (reg_idx == `FLC_IDX_FUSE4);
  wire       hit_fuse5   = aligned && (reg_idx == `FLC_IDX_FUSE5);
  wire       hit_lock    = aligned && (reg_idx == `FLC_IDX_LOCK);
  wire       hit_cmd     = aligned && (reg_idx == `FLC_IDX_CMD);
  wire       hit_status  = aligned && (reg_idx == `FLC_IDX_STATUS);
  wire       hit_fuse    = hit_fuse0 | hit_fuse1 | hit_fuse2 | hit_fuse4 | hit_fuse5;
  wire       mapped      = hit_fuse | hit_lock | hit_cmd | hit_status;
  wire       setup_ph    = psel && !penable;
  wire       access_ph   = psel && penable;
  wire       wr_access   = access_ph && pwrite;
  wire [7:0] wbyte       = pwdata[7:0];

  wire       fuse_busy   = (wr_cnt_q != '0);
  wire       cmd_reset   = wr_access && hit_cmd && (wbyte == `FLC_CMD_DEV_RESET);
  wire       cmd_erase   = wr_access && hit_cmd && (wbyte == `FLC_CMD_CHIP_ERASE);
  wire       fuse_wr_ok  = wr_access && hit_fuse && prog_access && !fuse_busy;
  wire       erase_ok    = cmd_erase && prog_access;
  wire       commit      = (wr_cnt_q == CNT_W'(1));

  // Refused: unmapped, misaligned, fuse write outside programming or while busy,
  // chip erase outside programming, unknown command
  wire       bad_fuse_wr = wr_access && hit_fuse && !(prog_access && !fuse_busy);
  wire       bad_cmd     = wr_access && hit_cmd && !cmd_reset && !(erase_ok);
  wire       lock_refuse = wr_access && hit_lock && (lock_d != wbyte);

  assign pready  = 1'b1;
  assign pslverr = access_ph && (!mapped || bad_fuse_wr || bad_cmd || lock_refuse);
  assign prdata  = prdata_q;

  // Pin synchronisers and slow oscillator edge
  wire ext_pin_low = !ext_s2_q;
  wire ulp_tick    = ulp_s2_q && !ulp_s3_q;
  // Loaded copy decides whether the pin is obeyed, matching the reset-time view
  wire ext_rst_req = ext_pin_low && shadow4_q[`FLC_F4_RSTDIS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ulp_s1_q <= 1'b0;
      ulp_s2_q <= 1'b0;
      ulp_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_reset_pin_n;
      ext_s2_q <= ext_s1_q;
      ulp_s1_q <= ulp_clk_pin;
      ulp_s2_q <= ulp_s1_q;
      ulp_s3_q <= ulp_s2_q;
    end
  end

  // Reset sequencer
  logic delay_done;

  flc_startup_delay u_delay (
    .pclk                 (pclk),
    .presetn              (presetn),
    .start                (state_q == ST_LOAD),
    .startup_delay_select (fuse4_q[`FLC_F4_STUP]),
    .ulp_tick             (ulp_tick),
    .done                 (delay_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:  if (!ext_rst_req) state_d = ST_LOAD;
      ST_LOAD:  state_d = ST_DELAY;
      ST_DELAY: if (delay_done) state_d = ST_RUN;
      ST_RUN:   if (cmd_reset) state_d = ST_LOAD;
      default:  state_d = ST_HOLD;
    endcase
    if (ext_rst_req) begin
      state_d = ST_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q            <= ST_HOLD;
      internal_reset_n_q <= 1'b0;
    end else begin
      state_q            <= state_d;
      internal_reset_n_q <= (state_d == ST_RUN);
    end
  end

  assign internal_reset_n = internal_reset_n_q;

  // Reset cause flags: write one to clear, a new cause in the same cycle wins
  wire [2:0] cause_set = {cmd_reset, ext_rst_req, 1'b0};
  wire [2:0] cause_clr = (wr_access && hit_status) ?
                         pwdata[`FLC_ST_SW:`FLC_ST_POR] : 3'h0;

  always_comb begin
    cause_d = (cause_q & ~cause_clr) | cause_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 3'h1;
    end else begin
      cause_q <= cause_d;
    end
  end

  // Fuse programming with write timeout; reserved bits kept as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt_q    <= '0;
      pend_idx_q  <= `FLC_IDX_FUSE0;
      pend_data_q <= `FLC_FUSE_RESET;
    end else if (fuse_wr_ok) begin
      wr_cnt_q    <= CNT_W'(FUSE_WR_CYCLES);
      pend_idx_q  <= reg_idx;
      pend_data_q <= wbyte;
    end else if (fuse_busy) begin
      wr_cnt_q    <= wr_cnt_q - CNT_W'(1);
    end
  end

  // Fuses erase to all ones; a programmed bit is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse0_q <= `FLC_FUSE_RESET;
      fuse1_q <= `FLC_FUSE_RESET;
      fuse2_q <= `FLC_FUSE_RESET;
      fuse4_q <= `FLC_FUSE_RESET;
      fuse5_q <= `FLC_FUSE_RESET;
    end else if (commit) begin
      if (pend_idx_q == `FLC_IDX_FUSE0) fuse0_q <= pend_data_q;
      if (pend_idx_q == `FLC_IDX_FUSE1) fuse1_q <= pend_data_q;
      if (pend_idx_q == `FLC_IDX_FUSE2) fuse2_q <= pend_data_q;
      if (pend_idx_q == `FLC_IDX_FUSE4) fuse4_q <= pend_data_q;
      if (pend_idx_q == `FLC_IDX_FUSE5) fuse5_q <= pend_data_q;
    end
  end

  // Lock bits: writes move each field only toward more restriction; chip erase returns all to ones
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lock
      wire [1:0] old_f  = lock_q[2*gi+1:2*gi];
      wire [1:0] new_f  = wbyte[2*gi+1:2*gi];
      wire       port   = (gi != 0) || prog_access;
      wire       strict = ((new_f & ~old_f) == 2'h0);
      wire       take   = wr_access && hit_lock && port && strict;
      // Erase outranks a write; a refused field keeps its old code
      assign lock_d[2*gi+1:2*gi] = erase_ok ? `FLC_LOCK_FIELD_ONES :
                                   take     ? new_f                 :
                                              old_f;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= `FLC_LOCK_RESET;
    end else begin
      lock_q <= lock_d;
    end
  end

  // Chip erase strobes, one cycle after the command is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_q    <= 1'b0;
      erase_ee_q <= 1'b0;
    end else begin
      erase_q    <= erase_ok;
      erase_ee_q <= erase_ok && fuse5_q[`FLC_F5_EEPROM_PRESERVE];
    end
  end

  assign erase_flash  = erase_q;
  assign erase_sram   = erase_q;
  assign erase_eeprom = erase_ee_q;

  // Reset-time load of configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tuid_q    <= `FLC_FUSE_RESET;
      wdt_q     <= '0;
      bootvec_q <= 1'b1;
      slow_timer_oscillator_q    <= 1'b1;
      sleep_brownout_mode_q   <= 2'h3;
      active_brownout_mode_q  <= 2'h3;
      bodlvl_q  <= 3'h7;
      shadow4_q <= `FLC_FUSE_RESET;
    end else if (state_q == ST_LOAD) begin
      tuid_q                    <= fuse0_q;
      wdt_q.window_period_bits  <= fuse1_q[`FLC_F1_WINDOW_PERIOD_BITS];
      wdt_q.timeout_period_bits <= fuse1_q[`FLC_F1_PER];
      wdt_q.enable_force        <= !fuse4_q[`FLC_F4_WATCHDOG_CONFIG_LOCK];
      wdt_q.config_lock         <= !fuse4_q[`FLC_F4_WATCHDOG_CONFIG_LOCK];
      bootvec_q                 <= fuse2_q[`FLC_F2_BOOTVEC];
      slow_timer_oscillator_q                    <= fuse2_q[`FLC_F2_SLOW_TIMER_OSCILLATOR];
      sleep_brownout_mode_q                   <= fuse2_q[`FLC_F2_SLEEP_BROWNOUT_MODE];
      active_brownout_mode_q                  <= fuse5_q[`FLC_F5_ACTIVE_BROWNOUT_MODE];
      bodlvl_q                  <= fuse5_q[`FLC_F5_BODLVL];
      shadow4_q                 <= fuse4_q;
    end
  end

  // Window-mode enable is absent on purpose: locking forces only the main enable
  assign wdt_cfg              = wdt_q;
  assign test_user_identifier = tuid_q;
  assign reset_address        = bootvec_q ? `FLC_APP_RESET_ADDR : BOOT_START_ADDR;
  assign slow_osc_shared      = slow_timer_oscillator_q;
  assign test_port_enable     = !shadow4_q[`FLC_F4_TESTEN];

  assign bod_cfg.active_brownout_mode = flc_bod_decode(active_brownout_mode_q);
  assign bod_cfg.sleep_brownout_mode  = flc_bod_decode(sleep_brownout_mode_q);
  assign bod_cfg.effective_mode       = sleeping_deep ?
                                        flc_bod_decode(sleep_brownout_mode_q) :
                                        flc_bod_decode(active_brownout_mode_q);
  assign bod_cfg.brownout_threshold   = bodlvl_q;

  // Boot lock decode: low bit guards writes, high bit guards reads
  assign boot_write_block = !lock_q[`FLC_LK_BOOT_WR];
  assign boot_read_block  = !lock_q[`FLC_LK_BOOT_RD] && !exec_in_boot;
  assign irq_block        = !lock_q[`FLC_LK_BOOT_RD] && vectors_in_app &&
                            exec_in_boot;

  // Read data: byte 4 shows the copy taken at the last reset for its sticky bits
  wire [7:0] fuse4_rd = shadow4_q;
  wire [7:0] status_rd = {3'h0, cause_q, fuse5_q[`FLC_F5_EEPROM_PRESERVE], fuse_busy};

  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_fuse0)  rd_byte = fuse0_q;
    if (hit_fuse1)  rd_byte = fuse1_q;
    if (hit_fuse2)  rd_byte = fuse2_q;
    if (hit_fuse4)  rd_byte = fuse4_rd;
    if (hit_fuse5)  rd_byte = fuse5_q;
    if (hit_lock)   rd_byte = lock_q;
    if (hit_status) rd_byte = status_rd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

endmodule

// ==== tb/flc_pin_model.sv ====
// Slow oscillator and external reset pin as seen from outside the block
`timescale 1ns/10ps
module flc_pin_model #(
  parameter int ULP_HALF_NS = 200
) (
  // Request from the bench
  input  wire logic pull_reset,
  // Pins
  output logic      ulp_clk_pin,
  output logic      ext_reset_pin_n
);
  // Shortened period keeps the 64-tick start-up inside a short run
  initial begin
    ulp_clk_pin = 1'b0;
    forever #(ULP_HALF_NS) ulp_clk_pin = ~ulp_clk_pin;
  end
  // The pin has a pull-up, so it rests high unless pulled
  assign ext_reset_pin_n = ~pull_reset;
endmodule

// ==== tb/flc_monitor.sv ====
// Concurrent checks on the ports of the fuse and lock block
`timescale 1ns/10ps
module flc_monitor
  import flc_pkg::*;
#(
  parameter logic [15:0] BOOT_START_ADDR = 16'h8000
) (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // APB
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pslverr,
  // Processor status and loaded configuration
  input wire logic         exec_in_boot,
  input wire logic         vectors_in_app,
  input wire logic         sleeping_deep,
  input wire logic         internal_reset_n,
  input wire logic [15:0]  reset_address,
  input wire logic [7:0]   test_user_identifier,
  input wire flc_wdt_cfg_t wdt_cfg,
  input wire flc_bod_cfg_t bod_cfg,
  input wire logic         boot_read_block,
  input wire logic         irq_block,
  input wire logic         erase_flash,
  input wire logic         erase_sram,
  input wire logic         erase_eeprom
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Loaded copies may only move while the core is held in reset
  tuid_load_only_a: assert property (
    $changed(test_user_identifier) |-> !$past(internal_reset_n)) else $error("id moved in run");
  wdt_load_only_a: assert property (
    $changed(wdt_cfg) |-> !$past(internal_reset_n)) else $error("watchdog setup moved in run");
  boot_addr_pick_a: assert property (
    reset_address == 16'h0000 || reset_address == BOOT_START_ADDR) else $error("bad start addr");
  bod_select_a: assert property (
    bod_cfg.effective_mode == (sleeping_deep ? bod_cfg.sleep_brownout_mode
                                             : bod_cfg.active_brownout_mode))
    else $error("brown-out mode pick wrong");
  irq_cause_a: assert property (
    irq_block |-> exec_in_boot && vectors_in_app && !boot_read_block) else $error("irq block");
  erase_pulse_a: assert property (
    erase_flash |=> !erase_flash) else $error("erase pulse too long");
  erase_pair_a: assert property (
    erase_flash == erase_sram) else $error("flash and sram erase differ");
  eeprom_erase_a: assert property (
    erase_eeprom |-> erase_flash) else $error("eeprom erased alone");
  refuse_phase_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access phase");
endmodule

bind flc_top flc_monitor #(.BOOT_START_ADDR(BOOT_START_ADDR)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
  .exec_in_boot(exec_in_boot), .vectors_in_app(vectors_in_app),
  .sleeping_deep(sleeping_deep), .internal_reset_n(internal_reset_n),
  .reset_address(reset_address), .test_user_identifier(test_user_identifier),
  .wdt_cfg(wdt_cfg), .bod_cfg(bod_cfg), .boot_read_block(boot_read_block),
  .irq_block(irq_block), .erase_flash(erase_flash), .erase_sram(erase_sram),
  .erase_eeprom(erase_eeprom));

// ==== tb/testbench.sv ====
// Self-checking bench for the fuse and lock block
`timescale 1ns/10ps
`include "flc_params.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
  import flc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, prog_access, pull_reset;
  logic         exec_in_boot, vectors_in_app, sleeping_deep, seen_fl, seen_ee, err;
  logic         pready, pslverr, ulp_clk_pin, ext_reset_pin_n, internal_reset_n;
  logic         slow_osc_shared, test_port_enable, boot_write_block, boot_read_block;
  logic         irq_block, erase_flash, erase_sram, erase_eeprom;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [15:0]  reset_address;
  logic [7:0]   tuid;
  flc_wdt_cfg_t wdt_cfg;
  flc_bod_cfg_t bod_cfg;
  int           bad_count, comparisons, cycles, ticks;
  logic [9:0]   idx_list[6] = '{`FLC_IDX_FUSE0, `FLC_IDX_FUSE1, `FLC_IDX_FUSE2,
                                `FLC_IDX_FUSE4, `FLC_IDX_FUSE5, `FLC_IDX_LOCK};
  logic [7:0]   lk_w[7] = '{8'hbf, 8'hff, 8'h7f, 8'h3f, 8'h2f, 8'h2e, 8'h2e};
  logic [7:0]   lk_r[7] = '{8'hbf, 8'hbf, 8'hbf, 8'h3f, 8'h2f, 8'h2f, 8'h2e};

  flc_top #(.FUSE_WR_CYCLES(2)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_access(prog_access), .ext_reset_pin_n(ext_reset_pin_n),
    .ulp_clk_pin(ulp_clk_pin), .exec_in_boot(exec_in_boot),
    .vectors_in_app(vectors_in_app), .sleeping_deep(sleeping_deep),
    .internal_reset_n(internal_reset_n), .reset_address(reset_address),
    .test_user_identifier(tuid), .wdt_cfg(wdt_cfg), .slow_osc_shared(slow_osc_shared),
    .bod_cfg(bod_cfg), .test_port_enable(test_port_enable),
    .boot_write_block(boot_write_block), .boot_read_block(boot_read_block),
    .irq_block(irq_block), .erase_flash(erase_flash), .erase_sram(erase_sram),
    .erase_eeprom(erase_eeprom));
  flc_pin_model u_pins (
    .pull_reset(pull_reset), .ulp_clk_pin(ulp_clk_pin), .ext_reset_pin_n(ext_reset_pin_n));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge ulp_clk_pin) if (internal_reset_n === 1'b0) ticks++;
  always @(posedge pclk) begin
    if (erase_flash === 1'b1) seen_fl <= 1'b1;
    if (erase_eeprom === 1'b1) seen_ee <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Ready is sampled in the access cycle; the request holds until that edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic p);
    @(posedge pclk);
    psel        <= 1'b1;
    penable     <= 1'b0;
    pwrite      <= w;
    paddr       <= {idx, 2'b00};
    pwdata      <= {24'h00_0000, d};
    prog_access <= p;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fuse_wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 1'b1);
    `CHK("fuse write refused", 1'b0, err)
    do apb(1'b0, `FLC_IDX_STATUS, 8'h00, 1'b0); while (rd[0] !== 1'b0);
  endtask
  task automatic wait_run();
    while (internal_reset_n !== 1'b0) @(posedge pclk);
    while (internal_reset_n !== 1'b1) @(posedge pclk);
  endtask
  task automatic dev_reset();
    ticks = 0;
    apb(1'b1, `FLC_IDX_CMD, `FLC_CMD_DEV_RESET, 1'b0);
    wait_run();
  endtask
  task automatic erase();
    seen_fl = 1'b0;
    seen_ee = 1'b0;
    apb(1'b1, `FLC_IDX_CMD, `FLC_CMD_CHIP_ERASE, 1'b1);
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    {psel, penable, pwrite, prog_access, pull_reset} = '0;
    {exec_in_boot, vectors_in_app, sleeping_deep, seen_fl, seen_ee} = '0;
    paddr = '0;
    pwdata = '0;
    {bad_count, comparisons, cycles, ticks} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    ticks = 0;
    presetn <= 1'b1;
    wait_run();
    `CHK("ticks code 11", 1'b1, ticks <= 1)
    foreach (idx_list[i]) begin
      apb(1'b0, idx_list[i], 8'h00, 1'b0);
      `CHK("reset value", 32'h0000_00ff, rd)
    end
    apb(1'b0, 10'h003, 8'h00, 1'b0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, `FLC_IDX_FUSE0, 8'h00, 1'b0);
    `CHK("software fuse write err", 1'b1, err)
    `CHK("start addr app", 16'h0000, reset_address)
    `CHK("test port off", 1'b0, test_port_enable)
    // Reserved fuse bits are always written as ones
    fuse_wr(`FLC_IDX_FUSE0, 8'h5a);
    fuse_wr(`FLC_IDX_FUSE1, 8'h3c);
    fuse_wr(`FLC_IDX_FUSE2, 8'h9d);
    fuse_wr(`FLC_IDX_FUSE4, 8'hf4);
    fuse_wr(`FLC_IDX_FUSE5, 8'he3);
    `CHK("id before reset", 8'hff, tuid)
    apb(1'b0, `FLC_IDX_FUSE4, 8'h00, 1'b0);
    `CHK("fuse4 before reset", 32'h0000_00ff, rd)
    dev_reset();
    `CHK("ticks code 01", 1'b1, ticks >= 4 && ticks <= 6)
    `CHK("user id", 8'h5a, tuid)
    `CHK("window period", 4'h3, wdt_cfg.window_period_bits)
    `CHK("timeout period", 4'hc, wdt_cfg.timeout_period_bits)
    `CHK("wdt locks", 2'b11, {wdt_cfg.enable_force, wdt_cfg.config_lock})
    `CHK("start addr boot", 16'h8000, reset_address)
    `CHK("osc pins", 1'b0, slow_osc_shared)
    `CHK("active bod", BOD_CONTINUOUS, bod_cfg.active_brownout_mode)
    `CHK("sleep bod", BOD_SAMPLED, bod_cfg.sleep_brownout_mode)
    `CHK("bod level", 3'h3, bod_cfg.brownout_threshold)
    `CHK("test port on", 1'b1, test_port_enable)
    apb(1'b0, `FLC_IDX_FUSE4, 8'h00, 1'b0);
    `CHK("fuse4 after reset", 32'h0000_00f4, rd)
    sleeping_deep <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("sleeping bod", BOD_SAMPLED, bod_cfg.effective_mode)
    sleeping_deep <= 1'b0;
    pull_reset <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("pin reset", 1'b0, internal_reset_n)
    pull_reset <= 1'b0;
    wait_run();
    apb(1'b0, `FLC_IDX_STATUS, 8'h00, 1'b0);
    `CHK("reset causes", 32'h0000_001c, rd)
    apb(1'b1, `FLC_IDX_STATUS, 8'h1c, 1'b0);
    apb(1'b0, `FLC_IDX_STATUS, 8'h00, 1'b0);
    `CHK("causes cleared", 32'h0000_0000, rd)
    fuse_wr(`FLC_IDX_FUSE4, 8'he4);
    dev_reset();
    pull_reset <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("pin ignored", 1'b1, internal_reset_n)
    pull_reset <= 1'b0;
    fuse_wr(`FLC_IDX_FUSE4, 8'he0);
    dev_reset();
    `CHK("ticks code 00", 1'b1, ticks >= 64 && ticks <= 66)
    foreach (lk_w[i]) begin
      apb(1'b1, `FLC_IDX_LOCK, lk_w[i], i == 6);
      `CHK("lock err", lk_w[i] != lk_r[i], err)
      apb(1'b0, `FLC_IDX_LOCK, 8'h00, 1'b0);
      `CHK("lock value", {24'h00_0000, lk_r[i]}, rd)
    end
    `CHK("boot write block", 1'b1, boot_write_block)
    `CHK("boot read block", 1'b1, boot_read_block)
    exec_in_boot <= 1'b1;
    vectors_in_app <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("irq block", 1'b1, irq_block)
    erase();
    `CHK("flash erased", 1'b1, seen_fl)
    `CHK("eeprom kept", 1'b0, seen_ee)
    `CHK("lock open", 1'b0, boot_write_block)
    fuse_wr(`FLC_IDX_FUSE5, 8'heb);
    erase();
    `CHK("eeprom erased", 1'b1, seen_ee)
    final_report();
  end
endmodule
